/* pkg/acr_pkg.sv */
// Shared constants and types for the input and serializer configuration bank.
package acr_pkg;

  // Register byte addresses on the serial configuration port.
  localparam logic [14:0] ADDR_FS_B_LO = 15'h0032;
  localparam logic [14:0] ADDR_FS_B_HI = 15'h0033;
  localparam logic [14:0] ADDR_REF = 15'h0038;
  localparam logic [14:0] ADDR_STAMP = 15'h003B;
  localparam logic [14:0] ADDR_SER = 15'h0048;
  localparam logic [14:0] ADDR_ROUTE = 15'h0060;

  // Reset values.
  localparam logic [15:0] RST_FS_B = 16'hA000;
  localparam logic [7:0] RST_REF = 8'h00;
  localparam logic [7:0] RST_STAMP = 8'h00;
  localparam logic [7:0] RST_SER = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h01;

  // Field positions.
  localparam int REF_SUPPLY_BIT = 0;
  localparam int STAMP_ON_BIT = 0;
  localparam int STAMP_PECL_BIT = 1;
  localparam int EMPH_LSB = 0;
  localparam int EMPH_MSB = 2;
  localparam int EMPH_EXTRA_BIT = 3;
  localparam int SWAP_BIT = 4;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 1;

  // Serial frame: read flag, 15 address bits, 8 data bits.
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [4:0] FRAME_LAST = 5'h17;

  // Single-channel input select codes.
  typedef enum logic [1:0] {
    SEL_RESERVED = 2'h0,
    SEL_INPUT_A = 2'h1,
    SEL_INPUT_B = 2'h2,
    SEL_DUAL_DES = 2'h3
  } acr_sel_t;

  // Serial port frame state.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_HDR = 2'h1,
    ST_DATA = 2'h2,
    ST_DONE = 2'h3
  } acr_spi_st_t;

  // Decoded access from the serial port.
  typedef struct packed {
    logic write;
    logic [14:0] addr;
    logic [7:0] data;
  } acr_req_t;

endpackage

/* rtl/acr_spi_slave.sv */
// Serial configuration port slave, oversampled on the core clock.
`timescale 1ns/1ps
`default_nettype none
module acr_spi_slave (
  input wire logic clk, // Core clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic sclk, // Serial clock pin.
  input wire logic cs_n, // Chip select pin, active low.
  input wire logic sdi, // Serial data in pin.
  input wire logic [7:0] rd_data, // Read data for req_ff.addr.
  output logic sdo, // Serial data out.
  output logic sdo_oe, // Drive enable for sdo.
  output acr_pkg::acr_req_t req, // Current access.
  output logic req_valid // One-cycle write strobe.
);

  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic sclk_d_ff;
  logic [23:0] sh_ff;
  logic [4:0] cnt_ff;
  acr_pkg::acr_spi_st_t st_ff;
  acr_pkg::acr_req_t req_ff;
  logic valid_ff;
  logic load_ff;
  logic [7:0] tx_ff;
  logic sdo_ff;
  logic oe_ff;
  logic rise;
  logic fall;
  logic sdi_s;
  logic cs_s;

  // Two-stage synchronisers for the three pins; only stage two is read.
  // Reset levels match the idle pins, so no false clock edge follows reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= 3'h4;
      s2_ff <= 3'h4;
      sclk_d_ff <= 1'b0;
    end else begin
      s1_ff <= {cs_n, sdi, sclk};
      s2_ff <= s1_ff;
      sclk_d_ff <= s2_ff[0];
    end
  end

  assign rise = s2_ff[0] & ~sclk_d_ff;
  assign fall = ~s2_ff[0] & sclk_d_ff;
  assign sdi_s = s2_ff[1];
  assign cs_s = s2_ff[2];

  // Frame sequencing; a short frame is dropped when select rises.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= acr_pkg::ST_IDLE;
      cnt_ff <= 5'h00;
      sh_ff <= 24'h000000;
    end else if (cs_s) begin
      st_ff <= acr_pkg::ST_IDLE;
      cnt_ff <= 5'h00;
    end else begin
      case (st_ff)
        acr_pkg::ST_IDLE: begin
          st_ff <= acr_pkg::ST_HDR;
          cnt_ff <= 5'h00;
        end
        acr_pkg::ST_HDR, acr_pkg::ST_DATA: begin
          if (rise) begin
            sh_ff <= {sh_ff[22:0], sdi_s};
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == acr_pkg::HDR_LAST) begin
              st_ff <= acr_pkg::ST_DATA;
            end
            if (cnt_ff == acr_pkg::FRAME_LAST) begin
              st_ff <= acr_pkg::ST_DONE;
            end
          end
        end
        acr_pkg::ST_DONE: begin
          st_ff <= acr_pkg::ST_DONE;
        end
        default: begin
          st_ff <= acr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Header capture, write strobe and read-data load request.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ff <= '0;
      valid_ff <= 1'b0;
      load_ff <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      load_ff <= 1'b0;
      if (!cs_s && rise && st_ff == acr_pkg::ST_HDR &&
          cnt_ff == acr_pkg::HDR_LAST) begin
        req_ff.write <= ~sh_ff[14];
        req_ff.addr <= {sh_ff[13:0], sdi_s};
        load_ff <= sh_ff[14];
      end
      if (!cs_s && rise && st_ff == acr_pkg::ST_DATA &&
          cnt_ff == acr_pkg::FRAME_LAST) begin
        req_ff.data <= {sh_ff[6:0], sdi_s};
        valid_ff <= req_ff.write;
      end
    end
  end

  // Read data leaves MSB first, changing on falling serial clock edges.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_ff <= 8'h00;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (cs_s) begin
      oe_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end else if (load_ff) begin
      tx_ff <= rd_data;
      oe_ff <= 1'b1;
    end else if (fall && oe_ff && st_ff == acr_pkg::ST_DATA) begin
      sdo_ff <= tx_ff[7];
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  assign sdo = sdo_ff;
  assign sdo_oe = oe_ff;
  assign req = req_ff;
  assign req_valid = valid_ff;

endmodule
`default_nettype wire

/* rtl/acr_cfg_regs.sv */
// Input range, reference, timestamp receiver, lane emphasis and routing bank.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] Input B full-scale code, 16 bits read/write, resets to A000 hex.
// [R2] Software keeps the code at or above 2000 hex; lower codes still stored.
// [R3] Reference bit 0 selects the analog core supply; bits 7:1 plain storage.
// [R4] Timestamp control bit 0 turns the timestamp receiver on.
// [R5] Timestamp control bit 1 selects PECL receiver mode; bits 7:2 stored.
// [R6] Serializer bits 2:0 set one emphasis level shared by all sixteen lanes.
// [R7] Serializer bit 3 adds extra emphasis boost on every lane.
// [R8] Dual-channel mode: swap bit 4 clear is straight, set crosses inputs.
// [R9] Swap bit is ignored in single-channel modes.
// [R10] Select field 1:0 resets to 1: reserved, input A, input B, dual.
// [R11] Select field is ignored outside single-channel modes.
// [R12] Routing changes take effect only when a calibration starts.
// [R13] Software starts calibration by raising the enable, clears it to hold.
// [R14] Fields other than routing drive their functions right after a write; all read back.
module acr_cfg_regs (
  input wire logic clk, // Configuration clock, 100 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic cfg_sclk, // Serial port clock pin.
  input wire logic cfg_cs_n, // Serial port select pin, active low.
  input wire logic cfg_sdi, // Serial port data in pin.
  output logic cfg_sdo, // Serial port data out.
  output logic cfg_sdo_oe, // High while cfg_sdo is driven.
  input wire logic single_channel_mode, // Operating mode is single-channel.
  input wire logic cal_enable, // Calibration enable level.
  output logic [15:0] input_b_fullscale_code, // Input B range trim.
  output logic reference_from_supply, // Reference from core supply.
  output logic stamp_receiver_on, // Timestamp receiver enable.
  output logic stamp_receiver_pecl_mode, // Timestamp receiver PECL mode.
  output logic [2:0] lane_emphasis_level, // Lane pre-emphasis level.
  output logic lane_emphasis_extra, // Lane pre-emphasis boost.
  output logic chan_a_from_input_b, // Channel A samples input B.
  output logic chan_b_from_input_a, // Channel B samples input A.
  output logic chan_b_sampling // Channel B takes part in sampling.
);

  acr_pkg::acr_req_t req;
  logic req_valid;
  logic [7:0] rd_data;
  logic [15:0] fs_b_ff;
  logic [7:0] ref_ff;
  logic [7:0] stamp_ff;
  logic [7:0] ser_ff;
  logic [7:0] route_ff;
  logic [7:0] applied_ff;
  logic cal_d_ff;
  logic cal_start;
  logic a_from_b_ff;
  logic b_from_a_ff;
  logic b_used_ff;
  logic [1:0] sel;
  logic swap;

  // Address match shared by the write and read decoders.
  function automatic logic hit(input logic [14:0] a, input logic [14:0] t);
    hit = (a == t);
  endfunction

  acr_spi_slave u_spi (
    .clk(clk),
    .reset_n(reset_n),
    .sclk(cfg_sclk),
    .cs_n(cfg_cs_n),
    .sdi(cfg_sdi),
    .rd_data(rd_data),
    .sdo(cfg_sdo),
    .sdo_oe(cfg_sdo_oe),
    .req(req),
    .req_valid(req_valid)
  );

  // Register writes; every bit, reserved ones too, is stored.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fs_b_ff <= acr_pkg::RST_FS_B;
      ref_ff <= acr_pkg::RST_REF;
      stamp_ff <= acr_pkg::RST_STAMP;
      ser_ff <= acr_pkg::RST_SER;
      route_ff <= acr_pkg::RST_ROUTE;
    end else if (req_valid) begin
      if (hit(req.addr, acr_pkg::ADDR_FS_B_LO)) begin
        fs_b_ff[7:0] <= req.data; // R1 R2
      end
      if (hit(req.addr, acr_pkg::ADDR_FS_B_HI)) begin
        fs_b_ff[15:8] <= req.data; // R1 R2
      end
      if (hit(req.addr, acr_pkg::ADDR_REF)) begin
        ref_ff <= req.data; // R3
      end
      if (hit(req.addr, acr_pkg::ADDR_STAMP)) begin
        stamp_ff <= req.data; // R4 R5
      end
      if (hit(req.addr, acr_pkg::ADDR_SER)) begin
        ser_ff <= req.data; // R6 R7
      end
      if (hit(req.addr, acr_pkg::ADDR_ROUTE)) begin
        route_ff <= req.data; // R10
      end
    end
  end

  // Read-back of stored values; unmapped addresses return zero.
  always_comb begin
    rd_data = 8'h00;
    if (hit(req.addr, acr_pkg::ADDR_FS_B_LO)) begin
      rd_data = fs_b_ff[7:0]; // R14
    end else if (hit(req.addr, acr_pkg::ADDR_FS_B_HI)) begin
      rd_data = fs_b_ff[15:8]; // R14
    end else if (hit(req.addr, acr_pkg::ADDR_REF)) begin
      rd_data = ref_ff;
    end else if (hit(req.addr, acr_pkg::ADDR_STAMP)) begin
      rd_data = stamp_ff;
    end else if (hit(req.addr, acr_pkg::ADDR_SER)) begin
      rd_data = ser_ff;
    end else if (hit(req.addr, acr_pkg::ADDR_ROUTE)) begin
      rd_data = route_ff;
    end
  end

  // Direct trims follow their register bits immediately.
  assign input_b_fullscale_code = fs_b_ff; // R1 R14
  assign reference_from_supply = ref_ff[acr_pkg::REF_SUPPLY_BIT]; // R3
  assign stamp_receiver_on = stamp_ff[acr_pkg::STAMP_ON_BIT]; // R4
  assign stamp_receiver_pecl_mode = stamp_ff[acr_pkg::STAMP_PECL_BIT]; // R5
  assign lane_emphasis_level =
    ser_ff[acr_pkg::EMPH_MSB:acr_pkg::EMPH_LSB]; // R6
  assign lane_emphasis_extra = ser_ff[acr_pkg::EMPH_EXTRA_BIT]; // R7

  // A rising calibration enable latches the routing the analog core uses.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_d_ff <= 1'b0;
      applied_ff <= acr_pkg::RST_ROUTE;
    end else begin
      cal_d_ff <= cal_enable;
      if (cal_start) begin
        applied_ff <= route_ff; // R12 R13
      end
    end
  end

  assign cal_start = cal_enable & ~cal_d_ff; // R13
  assign sel = applied_ff[acr_pkg::SEL_MSB:acr_pkg::SEL_LSB];
  assign swap = applied_ff[acr_pkg::SWAP_BIT];

  // Sampling input routing from the mode and the calibrated selection.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      a_from_b_ff <= 1'b0;
      b_from_a_ff <= 1'b0;
      b_used_ff <= 1'b1;
    end else if (single_channel_mode) begin
      b_from_a_ff <= 1'b0; // R9
      a_from_b_ff <= (sel == acr_pkg::SEL_INPUT_B); // R10
      b_used_ff <= (sel == acr_pkg::SEL_DUAL_DES); // R10
    end else begin
      a_from_b_ff <= swap; // R8 R11
      b_from_a_ff <= swap; // R8
      b_used_ff <= 1'b1;
    end
  end

  assign chan_a_from_input_b = a_from_b_ff;
  assign chan_b_from_input_a = b_from_a_ff;
  assign chan_b_sampling = b_used_ff;

  // Checks on the stored fields and the routing.
  fs_low_write_a: assert property (@(posedge clk) disable iff (!reset_n) // R1
    req_valid && req.addr == acr_pkg::ADDR_FS_B_LO
    |=> input_b_fullscale_code[7:0] == $past(req.data))
    else $error("input B range low byte not written");
  fs_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // R14
    !req_valid |=> $stable(input_b_fullscale_code))
    else $error("input B range changed without a write");
  ref_write_a: assert property (@(posedge clk) disable iff (!reset_n) // R3
    req_valid && req.addr == acr_pkg::ADDR_REF
    |=> reference_from_supply == $past(req.data[0]))
    else $error("reference select not written");
  stamp_on_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
    req_valid && req.addr == acr_pkg::ADDR_STAMP
    |=> stamp_receiver_on == $past(req.data[0]))
    else $error("timestamp receiver enable not written");
  stamp_pecl_a: assert property (@(posedge clk) disable iff (!reset_n) // R5
    req_valid && req.addr == acr_pkg::ADDR_STAMP
    |=> stamp_receiver_pecl_mode == $past(req.data[1]))
    else $error("timestamp PECL mode not written");
  emph_level_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
    req_valid && req.addr == acr_pkg::ADDR_SER
    |=> lane_emphasis_level == $past(req.data[2:0]))
    else $error("lane emphasis level not written");
  emph_extra_a: assert property (@(posedge clk) disable iff (!reset_n) // R7
    req_valid && req.addr == acr_pkg::ADDR_SER
    |=> lane_emphasis_extra == $past(req.data[3]))
    else $error("lane emphasis boost not written");
  dual_swap_a: assert property (@(posedge clk) disable iff (!reset_n) // R8
    !single_channel_mode |=> chan_a_from_input_b == $past(swap)
    && chan_b_from_input_a == $past(swap) && chan_b_sampling)
    else $error("dual-channel routing does not follow swap");
  single_sel_a: assert property (@(posedge clk) disable iff (!reset_n) // R10
    single_channel_mode |=> !chan_b_from_input_a
    && chan_a_from_input_b == ($past(sel) == acr_pkg::SEL_INPUT_B)
    && chan_b_sampling == ($past(sel) == acr_pkg::SEL_DUAL_DES))
    else $error("single-channel routing wrong or swap not ignored");
  cal_apply_a: assert property (@(posedge clk) disable iff (!reset_n) // R12
    !cal_start |=> $stable(applied_ff))
    else $error("routing changed without calibration start");
  cal_take_a: assert property (@(posedge clk) disable iff (!reset_n) // R12
    cal_start |=> applied_ff == $past(route_ff))
    else $error("calibration start did not take routing");

  fs_write_c: cover property (@(posedge clk) disable iff (!reset_n)
    req_valid && req.addr == acr_pkg::ADDR_FS_B_HI);
  cal_start_c: cover property (@(posedge clk) disable iff (!reset_n)
    cal_start && route_ff != applied_ff);
  swap_on_c: cover property (@(posedge clk) disable iff (!reset_n)
    !single_channel_mode && swap);
  dual_des_c: cover property (@(posedge clk) disable iff (!reset_n)
    single_channel_mode && sel == acr_pkg::SEL_DUAL_DES);

endmodule
`default_nettype wire

/* bench/acr_host_model.sv */
// Host model that runs frames on the configuration serial port.
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
  input wire logic clk, // Core clock.
  input wire logic sdo, // Serial read data.
  input wire logic sdo_oe, // Read data drive enable.
  output logic sclk, // Serial clock, idle low.
  output logic cs_n, // Select, active low.
  output logic sdi // Serial write data.
);
  // Half period of sclk in core clocks; the port needs at least three.
  localparam int HALF = 5;
  logic [23:0] word;

  // The port idles deselected with the serial clock low.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // One 24-bit frame, MSB first; the last eight bits are sampled back.
  task automatic xfer(input logic rd, input logic [14:0] addr,
                      input logic [7:0] wdat, output logic [7:0] rdat,
                      output logic oe_seen);
    word = {rd, addr, wdat};
    rdat = 8'h00;
    oe_seen = 1'b1;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      sdi = word[i];
      repeat (HALF) @(negedge clk);
      if (i < 8) begin
        rdat = {rdat[6:0], sdo};
        oe_seen = oe_seen & sdo_oe;
      end
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    sdi = ~sdi; // A released data line does not keep its last value.
    repeat (2 * HALF) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* bench/acr_cfg_regs_bench.sv */
// Self-checking bench for the input and serializer configuration bank.
`timescale 1ns/1ps
`default_nettype none
module acr_cfg_regs_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic single_channel_mode = 1'b1;
  logic cal_enable = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe;
  logic [15:0] fs_code;
  logic [2:0] emph;
  logic ref_sup, st_on, st_pecl, emph_x, a_b, b_a, b_used;
  logic [15:0] rnd = 16'hD354;
  logic [7:0] sh[6];
  logic [7:0] app;
  logic [7:0] rd;
  logic oe;
  logic [14:0] addrs[6];
  int failures = 0;
  int check_count = 0;

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  acr_cfg_regs u_acr_cfg_regs (.clk(clk), .reset_n(reset_n),
    .cfg_sclk(sclk), .cfg_cs_n(cs_n), .cfg_sdi(sdi), .cfg_sdo(sdo),
    .cfg_sdo_oe(sdo_oe), .single_channel_mode(single_channel_mode),
    .cal_enable(cal_enable), .input_b_fullscale_code(fs_code),
    .reference_from_supply(ref_sup), .stamp_receiver_on(st_on),
    .stamp_receiver_pecl_mode(st_pecl), .lane_emphasis_level(emph),
    .lane_emphasis_extra(emph_x), .chan_a_from_input_b(a_b),
    .chan_b_from_input_a(b_a), .chan_b_sampling(b_used));

  acr_host_model u_acr_host_model (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  // Sixteen-bit LFSR that feeds the random register data.
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Expected routing as {a_from_b, b_from_a, b_sampling}.
  function automatic logic [2:0] route(input logic single,
                                       input logic [7:0] v);
    if (single)
      return {v[1:0] == 2'h2, 1'b0, v[1:0] == 2'h3};
    return {v[4], v[4], 1'b1};
  endfunction

  // Compares one value and counts it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Checks every function output against the shadow copy, and the routing against app.
  task automatic chk_outs();
    chk(fs_code, {sh[1], sh[0]});
    chk(16'(ref_sup), 16'(sh[2][0]));
    chk(16'(st_on), 16'(sh[3][0]));
    chk(16'(st_pecl), 16'(sh[3][1]));
    chk(16'(emph), 16'(sh[4][2:0]));
    chk(16'(emph_x), 16'(sh[4][3]));
    chk(16'({a_b, b_a, b_used}),
        16'(route(single_channel_mode, app)));
  endtask

  // Reads every register back through the serial port.
  task automatic rd_all();
    for (int i = 0; i < 6; i++) begin
      u_acr_host_model.xfer(1'b1, addrs[i], 8'h00, rd, oe);
      chk(16'(rd), 16'(sh[i]));
      chk(16'(oe), 16'h0001);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence: reset values, random writes, routing and calibration.
  initial begin
    addrs = '{acr_pkg::ADDR_FS_B_LO, acr_pkg::ADDR_FS_B_HI, acr_pkg::ADDR_REF,
              acr_pkg::ADDR_STAMP, acr_pkg::ADDR_SER, acr_pkg::ADDR_ROUTE};
    sh = '{8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h01};
    app = 8'h01;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_outs();
    rd_all();
    for (int it = 0; it < 8; it++) begin
      for (int r = 0; r < 6; r++) begin
        rnd = lfsr(rnd);
        sh[r] = (it == 0) ? 8'h00 : (it == 1) ? 8'hFF : rnd[7:0];
        if (r == 5)
          sh[r] = {rnd[7:5], it[0], rnd[3:2], it[2:1]};
        u_acr_host_model.xfer(1'b0, addrs[r], sh[r], rd, oe);
      end
      // Routing must still show the old value until calibration starts.
      chk_outs();
      rd_all();
      single_channel_mode = rnd[9];
      cal_enable = 1'b1;
      app = sh[5];
      repeat (3) @(negedge clk);
      chk_outs();
      single_channel_mode = ~single_channel_mode;
      repeat (2) @(negedge clk);
      chk_outs();
      cal_enable = 1'b0;
      repeat (2) @(negedge clk);
    end
    // An unmapped address stores nothing and reads zero.
    u_acr_host_model.xfer(1'b0, 15'h0034, 8'h5A, rd, oe);
    u_acr_host_model.xfer(1'b1, 15'h0034, 8'h00, rd, oe);
    chk(16'(rd), 16'h0000);
    chk_outs();
    rd_all();
    wrap_up();
  end

  // Cuts a hung run short and counts it as a failure.
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
